// *** common/pdl_cfg.svh ***
// Offsets, field positions, reset values and timing figures of the divider, hold and lock block
`ifndef PDL_CFG_SVH
`define PDL_CFG_SVH

// Register byte offsets
`define PDL_OFF_DIVSEL     8'h00
`define PDL_OFF_CFG2       8'h04
`define PDL_OFF_STATUS     8'h08
`define PDL_OFF_IRQ_STAT   8'h0C
`define PDL_OFF_IRQ_MASK   8'h10

// Divider select fields: three bits per output, output n at bit 3*n
`define PDL_SEL_W          3
`define PDL_DIVSEL_RST     32'h0000_3688

// Configuration word 2 fields
`define PDL_CFG2_HOLD_EN   2
`define PDL_CFG2_WIN_LO    6
`define PDL_CFG2_WIN_HI    7
`define PDL_CFG2_RST       32'h0000_0000

// Status bits
`define PDL_ST_LOCK        0
`define PDL_ST_HOLD        1

// Interrupt event bits
`define PDL_EV_LOCK_GAIN   0
`define PDL_EV_LOCK_LOSS   1
`define PDL_EV_HOLD_ENTER  2
`define PDL_EV_HOLD_EXIT   3
`define PDL_EV_W           4

// Timing figures
`define PDL_CLK_PERIOD_PS  25000
`define PDL_WIN0_PS        1200
`define PDL_WIN1_PS        1800
`define PDL_WIN2_PS        2400
`define PDL_WIN3_PS        3000
`define PDL_LOCK_PERIODS   5

`endif

// *** common/pdl_pkg.sv ***
// Types shared by the divider, hold and lock block
package pdl_pkg;

    typedef enum logic [2:0] {
        PDL_DIV1,
        PDL_DIV2,
        PDL_DIV4,
        PDL_DIV8,
        PDL_DIV16
    } pdl_div_e;

    typedef enum logic [1:0] {
        PDL_PH_IDLE,
        PDL_PH_REF_WAIT,
        PDL_PH_FB_WAIT
    } pdl_phase_e;

    typedef logic [1:0] pdl_win_t;

endpackage : pdl_pkg

// *** hw/pdl_top.sv ***
// Output divider selection, frequency hold and lock detection with an APB register file
//
// Overview of operation
// - each output divides oscillator by its select code
// - reset selects /1, /2, /4, /8, /8
// - first missing reference cycle enters hold
// - hold enable bit 2, off after reset
// - lock after five successive in-window periods
// - lock status output high while locked
// - window size from config bits 7:6
// - window codes 1.2/1.8/2.4/3 ns all round to a one-cycle (25 ns) window
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pdl_cfg.svh"

module pdl_top
    import pdl_pkg::*;
#(
    parameter int NUM_OUT      = 5,
    parameter int LOCK_PERIODS = `PDL_LOCK_PERIODS,
    parameter int PER_W        = 16
) (
    // Clock, reset, enable
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Clock pins
    input  wire logic               ref_clk_in,
    input  wire logic               oscillator_clock_in,
    input  wire logic               ref_div_in,
    input  wire logic               fb_div_in,
    // Divided outputs
    output logic [NUM_OUT-1:0]      clock_out,
    // Status
    output logic                    lock_status,
    output logic                    hold_active,
    output logic                    irq
);

    initial begin
        if (NUM_OUT < 1 || NUM_OUT > 10) $error("NUM_OUT must be 1..10");
        if (LOCK_PERIODS < 1 || LOCK_PERIODS > 255) $error("LOCK_PERIODS must be 1..255");
        if (PER_W < 4 || PER_W > 31) $error("PER_W must be 4..31");
    end

    // Window tolerance in whole cycles, rounded down, never below one
    function automatic logic [7:0] win_cycles(input int ps);
        int c;
        c = ps / `PDL_CLK_PERIOD_PS;
        if (c < 1) c = 1;
        return 8'(c);
    endfunction : win_cycles

    localparam logic [7:0] WIN0_CYC = win_cycles(`PDL_WIN0_PS);
    localparam logic [7:0] WIN1_CYC = win_cycles(`PDL_WIN1_PS);
    localparam logic [7:0] WIN2_CYC = win_cycles(`PDL_WIN2_PS);
    localparam logic [7:0] WIN3_CYC = win_cycles(`PDL_WIN3_PS);

    // Divider code to counter tap; unused codes fall back to /8
    function automatic pdl_div_e div_decode(input logic [2:0] code);
        unique case (code)
            3'b000:  return PDL_DIV1;
            3'b001:  return PDL_DIV2;
            3'b010:  return PDL_DIV4;
            3'b011:  return PDL_DIV8;
            3'b100:  return PDL_DIV16;
            default: return PDL_DIV8;
        endcase
    endfunction : div_decode

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else if (ce) begin
            sync1_q <= {fb_div_in, ref_div_in, oscillator_clock_in, ref_clk_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic ref_rise;
    logic osc_rise;
    logic pref_rise;
    logic pfb_rise;

    assign ref_rise  = ce & sync2_q[0] & ~sync3_q[0];
    assign osc_rise  = ce & sync2_q[1] & ~sync3_q[1];
    assign pref_rise = ce & sync2_q[2] & ~sync3_q[2];
    assign pfb_rise  = ce & sync2_q[3] & ~sync3_q[3];

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0]           divsel_q;
    logic [31:0]           cfg2_q;
    logic [`PDL_EV_W-1:0]  irq_stat_q;
    logic [`PDL_EV_W-1:0]  irq_mask_q;
    logic [`PDL_EV_W-1:0]  ev;
    logic                  lock_q;
    logic                  hold_q;
    logic                  wr_en;
    logic                  addr_ok;
    pdl_win_t              win_sel;

    assign win_sel = cfg2_q[`PDL_CFG2_WIN_HI:`PDL_CFG2_WIN_LO];

    always_comb begin
        unique case (paddr)
            `PDL_OFF_DIVSEL, `PDL_OFF_CFG2, `PDL_OFF_STATUS,
            `PDL_OFF_IRQ_STAT, `PDL_OFF_IRQ_MASK: addr_ok = 1'b1;
            default:                             addr_ok = 1'b0;
        endcase
    end

    // Stalling the bus while frozen keeps writes from being lost
    assign pready  = ce;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = ce & psel & penable & pwrite & addr_ok;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divsel_q <= `PDL_DIVSEL_RST;
        end else if (wr_en && paddr == `PDL_OFF_DIVSEL) begin
            // Mask keeps only the select fields of the outputs that exist, whatever NUM_OUT is
            divsel_q <= pwdata & ((32'h0000_0001 << (NUM_OUT*`PDL_SEL_W)) - 32'h0000_0001);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg2_q <= `PDL_CFG2_RST;
        end else if (wr_en && paddr == `PDL_OFF_CFG2) begin
            cfg2_q <= pwdata & 32'h0000_00C4;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= '0;
        end else if (wr_en && paddr == `PDL_OFF_IRQ_MASK) begin
            irq_mask_q <= pwdata[`PDL_EV_W-1:0];
        end
    end

    // A new event outranks a write-one-to-clear in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
        end else if (ce) begin
            if (wr_en && paddr == `PDL_OFF_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[`PDL_EV_W-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    // Read data captured in the setup phase, held through the access phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            unique case (paddr)
                `PDL_OFF_DIVSEL:   prdata <= divsel_q;
                `PDL_OFF_CFG2:     prdata <= cfg2_q;
                `PDL_OFF_STATUS:   prdata <= {30'h0, hold_q, lock_q};
                `PDL_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
                `PDL_OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_q};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Output dividers

    // One shared counter keeps the /2 to /16 outputs edge-aligned; /1 follows the synchronised pin a cycle earlier
    logic [3:0] div_cnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= 4'h0;
        end else if (osc_rise) begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    generate
        for (genvar n = 0; n < NUM_OUT; n++) begin : g_out
            pdl_div_e sel;
            assign sel = div_decode(divsel_q[n*3 +: 3]);

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    clock_out[n] <= 1'b0;
                end else if (ce) begin
                    unique case (sel)
                        PDL_DIV1:  clock_out[n] <= sync2_q[1];
                        PDL_DIV2:  clock_out[n] <= div_cnt_q[0];
                        PDL_DIV4:  clock_out[n] <= div_cnt_q[1];
                        PDL_DIV8:  clock_out[n] <= div_cnt_q[2];
                        PDL_DIV16: clock_out[n] <= div_cnt_q[3];
                    endcase
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Missing-reference detection and hold

    logic [PER_W-1:0] ref_timer_q;
    logic [PER_W-1:0] ref_period_q;
    logic             period_ok_q;
    logic             ref_missing;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_timer_q  <= '0;
            ref_period_q <= '0;
            period_ok_q  <= 1'b0;
        end else if (ce) begin
            if (ref_rise) begin
                ref_timer_q  <= '0;
                ref_period_q <= ref_timer_q + 1'b1;
                period_ok_q  <= 1'b1;
            end else if (~&ref_timer_q) begin
                ref_timer_q <= ref_timer_q + 1'b1;
            end
        end
    end

    // Missing once one and a half periods pass with no edge
    assign ref_missing = period_ok_q &&
        ({1'b0, ref_timer_q} > ({1'b0, ref_period_q} + {2'b00, ref_period_q[PER_W-1:1]}));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= 1'b0;
        end else if (ce) begin
            if (hold_q && ref_rise) begin
                hold_q <= 1'b0;
            end else if (!hold_q && cfg2_q[`PDL_CFG2_HOLD_EN] && ref_missing) begin
                hold_q <= 1'b1;
            end
        end
    end

    assign hold_active = hold_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Lock detector

    pdl_phase_e ph_q;
    logic [7:0] age_q;
    logic [7:0] win_cyc;
    logic [7:0] good_q;
    logic       in_win;
    logic       out_win;

    always_comb begin
        unique case (win_sel)
            2'b00: win_cyc = WIN0_CYC;
            2'b01: win_cyc = WIN1_CYC;
            2'b10: win_cyc = WIN2_CYC;
            2'b11: win_cyc = WIN3_CYC;
        endcase
    end

    // Edge pairing: first edge opens a wait, partner must come within the window
    always_comb begin
        in_win  = 1'b0;
        out_win = 1'b0;
        unique case (ph_q)
            PDL_PH_IDLE:     in_win = pref_rise & pfb_rise;
            PDL_PH_REF_WAIT: begin
                in_win  = pfb_rise & (age_q < win_cyc);
                out_win = (pfb_rise | pref_rise) ? ~in_win : (age_q >= win_cyc);
            end
            PDL_PH_FB_WAIT:  begin
                in_win  = pref_rise & (age_q < win_cyc);
                out_win = (pfb_rise | pref_rise) ? ~in_win : (age_q >= win_cyc);
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q  <= PDL_PH_IDLE;
            age_q <= 8'h00;
        end else if (ce) begin
            if (hold_q) begin
                ph_q <= PDL_PH_IDLE;
            end else begin
                unique case (ph_q)
                    PDL_PH_IDLE: begin
                        age_q <= 8'h00;
                        if (pref_rise && !pfb_rise) begin
                            ph_q <= PDL_PH_REF_WAIT;
                        end else if (pfb_rise && !pref_rise) begin
                            ph_q <= PDL_PH_FB_WAIT;
                        end
                    end
                    PDL_PH_REF_WAIT, PDL_PH_FB_WAIT: begin
                        age_q <= age_q + 8'h01;
                        if (in_win || out_win) begin
                            ph_q <= PDL_PH_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Hold freezes the qualification; it neither gains nor drops lock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            good_q <= 8'h00;
            lock_q <= 1'b0;
        end else if (ce && !hold_q) begin
            if (out_win) begin
                good_q <= 8'h00;
                lock_q <= 1'b0;
            end else if (in_win) begin
                if (good_q < 8'(LOCK_PERIODS - 1)) begin
                    good_q <= good_q + 8'h01;
                end else begin
                    lock_q <= 1'b1;
                end
            end
        end
    end

    assign lock_status = lock_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt events

    logic lock_d1_q;
    logic hold_d1_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_d1_q <= 1'b0;
            hold_d1_q <= 1'b0;
        end else if (ce) begin
            lock_d1_q <= lock_q;
            hold_d1_q <= hold_q;
        end
    end

    always_comb begin
        ev = '0;
        ev[`PDL_EV_LOCK_GAIN]  = ce & lock_q & ~lock_d1_q;
        ev[`PDL_EV_LOCK_LOSS]  = ce & ~lock_q & lock_d1_q;
        ev[`PDL_EV_HOLD_ENTER] = ce & hold_q & ~hold_d1_q;
        ev[`PDL_EV_HOLD_EXIT]  = ce & ~hold_q & hold_d1_q;
    end

endmodule : pdl_top

// *** sim/pdl_top_monitor.sv ***
// Port-level checker for the divider, hold and lock block
`timescale 1ns/1ps
`include "pdl_cfg.svh"
module pdl_top_monitor #(
    parameter int NUM_OUT      = 5,
    parameter int LOCK_PERIODS = 5
) (
    // Clock and enable
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic               ce,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Pins and status
    input wire logic               ref_clk_in,
    input wire logic               oscillator_clock_in,
    input wire logic               ref_div_in,
    input wire logic               fb_div_in,
    input wire logic [NUM_OUT-1:0] clock_out,
    input wire logic               lock_status,
    input wire logic               hold_active
);
    logic       hold_en_q, ref_prev_q, rdiv_prev_q;
    logic [2:0] sel0_q;
    logic [3:0] sel_age_q, quiet_q, mis_q, good_q, since_bad_q;
    wire        wr_acc = psel && penable && pready && pwrite;

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction : sat_inc

    // Shadow of the configuration the checker needs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_en_q <= 1'b0;
            sel0_q    <= 3'h0;
            sel_age_q <= 4'h0;
        end else begin
            if (wr_acc && paddr == `PDL_OFF_CFG2) begin
                hold_en_q <= pwdata[`PDL_CFG2_HOLD_EN];
            end
            if (wr_acc && paddr == `PDL_OFF_DIVSEL) begin
                sel0_q    <= pwdata[2:0];
                sel_age_q <= 4'h0;
            end else if (!ce) begin
                // A frozen cycle stalls the pin pipeline, so restart the settling count
                sel_age_q <= 4'h0;
            end else begin
                sel_age_q <= sat_inc(sel_age_q);
            end
        end
    end

    // Pin history; a two-cycle mismatch means an out-of-window pair
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {ref_prev_q, rdiv_prev_q} <= 2'b00;
            {quiet_q, mis_q, good_q, since_bad_q} <= 16'h0000;
        end else begin
            ref_prev_q  <= ref_clk_in;
            rdiv_prev_q <= ref_div_in;
            quiet_q     <= (ref_clk_in && !ref_prev_q) ? 4'h0 : sat_inc(quiet_q);
            mis_q       <= (ref_div_in != fb_div_in) ? sat_inc(mis_q) : 4'h0;
            since_bad_q <= (mis_q == 4'h2) ? 4'h0 : sat_inc(since_bad_q);
            if (mis_q >= 4'h2) begin
                good_q <= 4'h0;
            end else if (ref_div_in && !rdiv_prev_q) begin
                good_q <= sat_inc(good_q);
            end
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_bad_pair;
        mis_q == 4'h2 && !hold_active;
    endsequence
    sequence s_lock_gain;
        $rose(lock_status);
    endsequence

    a_pready_ce: assert property (pready == ce)
        else $error("pready not equal to ce");
    a_slverr_map: assert property (pslverr == (psel && penable && (paddr > `PDL_OFF_IRQ_MASK || paddr[1:0] != 2'b00)))
        else $error("pslverr wrong for address");
    a_hold_needs_en: assert property ($rose(hold_active) |-> hold_en_q)
        else $error("hold entered while disabled");
    a_hold_after_gap: assert property ($rose(hold_active) |-> quiet_q >= 4'h8)
        else $error("hold entered with reference running");
    a_hold_exit_ref: assert property ($fell(hold_active) |-> quiet_q <= 4'h6)
        else $error("hold left without reference edge");
    a_lock_after_five: assert property (s_lock_gain |-> good_q >= LOCK_PERIODS)
        else $error("lock declared too early");
    a_lock_drop_bad: assert property (s_bad_pair |-> ##[1:12] !lock_status)
        else $error("lock kept after bad pair");
    a_lock_fall_cause: assert property ($fell(lock_status) |-> since_bad_q <= 4'hC)
        else $error("lock dropped without bad pair");
    a_div1_osc: assert property (sel_age_q > 4'h4 && sel0_q == 3'h0 |-> clock_out[0] == $past(oscillator_clock_in, 3))
        else $error("divide by one output wrong");
endmodule : pdl_top_monitor

bind pdl_top pdl_top_monitor #(.NUM_OUT(NUM_OUT), .LOCK_PERIODS(LOCK_PERIODS)) u_mon (
    .clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .ref_clk_in, .oscillator_clock_in, .ref_div_in, .fb_div_in, .clock_out, .lock_status, .hold_active);

// *** sim/pdl_ref_osc_model.sv ***
// Reference source and oscillator model driving the clock pins
`timescale 1ns/1ps
module pdl_ref_osc_model (
    // Clock and controls
    input  wire logic       clk,
    input  wire logic       ref_run,
    input  wire logic [2:0] skew,
    // Pins
    output logic            ref_clk_in          = 1'b0,
    output logic            oscillator_clock_in = 1'b0,
    output logic            ref_div_in          = 1'b0,
    output logic            fb_div_in           = 1'b0
);
    logic [3:0] ref_cnt_q = 4'h0;
    logic [1:0] osc_cnt_q = 2'h0;
    logic       run_q     = 1'b0;
    logic [7:0] hist_q    = 8'h00;
    wire        rc        = run_q && (ref_cnt_q < 4'h8);

    // Reference at clk/16, far below the hold limit; stops low, whole periods only
    always @(posedge clk) begin
        ref_cnt_q <= ref_cnt_q + 4'h1;
        osc_cnt_q <= osc_cnt_q + 2'h1;
        if (ref_cnt_q == 4'hF) begin
            run_q <= ref_run;
        end
        if (osc_cnt_q == 2'h3) begin
            oscillator_clock_in <= !oscillator_clock_in;
        end
        ref_clk_in <= rc;
        ref_div_in <= rc;
        hist_q     <= {hist_q[6:0], rc};
        fb_div_in  <= (skew == 3'h0) ? rc : hist_q[skew - 3'h1];
    end
endmodule : pdl_ref_osc_model

// *** sim/pdl_top_test.sv ***
// Self-checking bench for the divider, hold and lock block
`timescale 1ns/1ps
`include "pdl_cfg.svh"
module pdl_top_test;
    logic        clk = 1'b0, arst_n = 1'b0, ce = 1'b1, ref_run = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat, word;
    logic        pready, pslverr, rerr, lock_status, hold_active, irq;
    logic        ref_clk_in, oscillator_clock_in, ref_div_in, fb_div_in;
    logic [4:0]  clock_out;
    logic [2:0]  skew = 3'h4;
    int          mismatches = 0, n_checks = 0, cycles = 0, n;
    wire  [5:0]  taps = {ref_div_in, clock_out};

    always #12.5 clk = ~clk;

    pdl_top u_dut (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ref_clk_in, .oscillator_clock_in, .ref_div_in, .fb_div_in, .clock_out, .lock_status, .hold_active, .irq);
    pdl_ref_osc_model u_src (.clk, .ref_run, .skew, .ref_clk_in, .oscillator_clock_in, .ref_div_in, .fb_div_in);

    ////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rdat);
    endtask : rchk

    // Rising edge as seen at successive clock samples; n gives the cycles waited
    task automatic wait_rise(input int t);
        logic p;
        n = 0;
        do begin
            p = taps[t];
            @(posedge clk);
            n++;
        end while (!(taps[t] === 1'b1 && p === 1'b0) && n < 400);
    endtask : wait_rise

    task automatic wait_hold(input logic v, input int lim);
        n = 0;
        while (hold_active !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check("hold flag", {31'h0, v}, {31'h0, hold_active});
    endtask : wait_hold

    function automatic int div_of(input int c);
        return (c < 4) ? (1 << c) : ((c == 4) ? 16 : 8);
    endfunction : div_of

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rchk("divider selects", `PDL_OFF_DIVSEL, 32'h0000_3688);
        rchk("config word", `PDL_OFF_CFG2, 32'h0000_0000);
        rchk("status", `PDL_OFF_STATUS, 32'h0000_0000);
        rchk("irq mask", `PDL_OFF_IRQ_MASK, 32'h0000_0000);
        rchk("unmapped read", 8'h14, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, rerr});
        ce <= 1'b0;
        @(posedge clk);
        #1 check("ready with ce low", 32'h0000_0000, {31'h0, pready});
        ce <= 1'b1;
        // Rotate codes so every output sees every select value
        for (int c = 0; c < 8; c++) begin
            word = 32'h0000_0000;
            for (int o = 0; o < 5; o++) word[3*o +: 3] = 3'((c + o) % 8);
            apb(1'b1, `PDL_OFF_DIVSEL, word);
            for (int o = 0; o < 5; o++) begin
                repeat (3) wait_rise(o);
                check("divider period", 32'(8 * div_of((c + o) % 8)), 32'(n));
            end
        end
        // Skew changes only while both divided edges are low
        wait_rise(5);
        repeat (13) @(posedge clk);
        skew <= 3'h0;
        repeat (4) wait_rise(5);
        repeat (6) @(posedge clk);
        check("lock after four", 32'h0000_0000, {31'h0, lock_status});
        wait_rise(5);
        repeat (6) @(posedge clk);
        check("lock after five", 32'h0000_0001, {31'h0, lock_status});
        rchk("status locked", `PDL_OFF_STATUS, 32'h0000_0001);
        wait_rise(5);
        repeat (13) @(posedge clk);
        skew <= 3'h4;
        wait_rise(5);
        repeat (12) @(posedge clk);
        check("lock after bad pair", 32'h0000_0000, {31'h0, lock_status});
        rchk("lock events", `PDL_OFF_IRQ_STAT, 32'h0000_0003);
        check("irq masked", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, `PDL_OFF_IRQ_MASK, 32'h0000_000F);
        rchk("irq mask", `PDL_OFF_IRQ_MASK, 32'h0000_000F);
        check("irq unmasked", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, `PDL_OFF_IRQ_STAT, 32'h0000_0003);
        rchk("events cleared", `PDL_OFF_IRQ_STAT, 32'h0000_0000);
        check("irq cleared", 32'h0000_0000, {31'h0, irq});
        wait_rise(5);
        ref_run <= 1'b0;
        repeat (60) @(posedge clk);
        check("hold while disabled", 32'h0000_0000, {31'h0, hold_active});
        ref_run <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, `PDL_OFF_CFG2, 32'(w << 6));
            rchk("window field", `PDL_OFF_CFG2, 32'(w << 6));
        end
        apb(1'b1, `PDL_OFF_CFG2, 32'hFFFF_FFFF);
        rchk("config word", `PDL_OFF_CFG2, 32'h0000_00C4);
        repeat (2) wait_rise(5);
        ref_run <= 1'b0;
        wait_hold(1'b1, 36);
        rchk("status hold", `PDL_OFF_STATUS, 32'h0000_0002);
        check("irq on hold", 32'h0000_0001, {31'h0, irq});
        repeat (30) @(posedge clk);
        ref_run <= 1'b1;
        wait_hold(1'b0, 60);
        rchk("hold events", `PDL_OFF_IRQ_STAT, 32'h0000_000C);
        report_and_stop();
    end
endmodule : pdl_top_test
